// >>> verilog/cau_cfg.svh
`ifndef CAU_CFG_SVH
`define CAU_CFG_SVH
// internal clock is the oscillator divided by two
`define CAU_CLK_DIV 2
// shortest instruction, in internal clocks
`define CAU_MIN_INSN_CLKS 2
// multiply and divide lengths, in internal clocks
`define CAU_MUL_CLKS 14
`define CAU_DIV_CLKS 43
// total ram, main ram and peripheral ram bounds
`define CAU_RAM_BYTES 640
`define CAU_MAIN_BASE 16'hfe00
`define CAU_MAIN_TOP 16'hfeff
`define CAU_PERI_BASE 16'hfc80
`define CAU_PERI_TOP 16'hfdff
// main ram access clocks per mode
`define CAU_MEM_CLKS 2
`define CAU_SADDR_CLKS 1
`define CAU_REG_CLKS 1
// peripheral ram access clocks per byte
`define CAU_PERI_CLKS 3
// register banks live at the top of main ram
`define CAU_BANK_BASE 8'h80
`define CAU_BANKS 8
`define CAU_REGS_PER_BANK 16
// call tables
`define CAU_VECTOR_TABLE_CALL_ENTRIES 32
`define CAU_VECTOR_TABLE_CALL_BASE_LO 16'h0040
`define CAU_VECTOR_TABLE_CALL_BASE_HI 16'h8040
`define CAU_FIXED_AREA_CALL_BASE 16'h0800
`endif

// >>> verilog/cau_pkg.sv
package cau_pkg;
    // arithmetic and call operation codes
    typedef enum logic [2:0] {
        CAU_OP_NONE,
        CAU_OP_MULU,
        CAU_OP_MULS,
        CAU_OP_DIVU,
        CAU_OP_MAC,
        CAU_OP_VECTOR_TABLE_CALL,
        CAU_OP_FIXED_AREA_CALL
    } cau_op_t;
    // ram access modes
    typedef enum logic [1:0] {
        CAU_ACC_MEM,
        CAU_ACC_SADDR,
        CAU_ACC_REG
    } cau_acc_t;
endpackage

// >>> verilog/cau_ram_if.sv
`timescale 1ns/1ps
// request and answer group between core and ram
interface cau_ram_if;
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [1:0] mode;
    logic ack;
    logic [7:0] rdata;
    logic err;
    modport core (output req, output wr, output addr, output wdata, output mode, input ack, input rdata, input err);
    modport ram (input req, input wr, input addr, input wdata, input mode, output ack, output rdata, output err);
endinterface

// >>> verilog/cau_ram.sv
`timescale 1ns/1ps
`include "cau_cfg.svh"
// on-chip ram with main and peripheral timing
module cau_ram
    import cau_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    cau_ram_if.ram bus
);
    logic [7:0] mem_reg [`CAU_RAM_BYTES]; // flop storage, main then peripheral
    logic [1:0] wait_reg; // remaining wait clocks
    logic busy_reg; // access in progress
    // map an address to a storage index
    function automatic logic [9:0] ram_index(input logic [15:0] a);
        if (a >= `CAU_MAIN_BASE)
            ram_index = {2'h0, a[7:0]};
        else
            ram_index = 10'(a - `CAU_PERI_BASE) + 10'h100;
    endfunction
    // clocks an access takes
    function automatic logic [1:0] acc_clks(input logic [15:0] a, input logic [1:0] m);
        if (a < `CAU_MAIN_BASE)
            acc_clks = 2'(`CAU_PERI_CLKS); // [RULE11]
        else if (m == CAU_ACC_MEM)
            acc_clks = 2'(`CAU_MEM_CLKS); // [RULE10]
        else
            acc_clks = 2'(`CAU_SADDR_CLKS); // [RULE9] [RULE10]
    endfunction
    wire in_map = bus.addr >= `CAU_PERI_BASE && bus.addr <= `CAU_MAIN_TOP;
    // access sequencing: ack after the access time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            wait_reg <= 2'h0;
            bus.ack <= 1'b0;
            bus.err <= 1'b0;
            bus.rdata <= 8'h00;
        end else if (ce) begin
            bus.ack <= 1'b0;
            // no new access while the last answer still stands, so a held request is not served twice
            if (!busy_reg && bus.req && !bus.ack) begin
                busy_reg <= 1'b1;
                wait_reg <= acc_clks(bus.addr, bus.mode) - 2'h1;
            end else if (busy_reg && wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end else if (busy_reg) begin
                busy_reg <= 1'b0;
                bus.ack <= 1'b1;
                bus.err <= !in_map;
                bus.rdata <= in_map ? mem_reg[ram_index(bus.addr)] : 8'h00; // [RULE8]
            end
        end
    end
    // storage write, whole main ram usable as data [RULE12]
    always_ff @(posedge clk) begin
        if (ce && busy_reg && wait_reg == 2'h0 && bus.wr && in_map)
            mem_reg[ram_index(bus.addr)] <= bus.wdata;
    end
endmodule // cau_ram

// >>> verilog/cau_core.sv
`timescale 1ns/1ps
`include "cau_cfg.svh"
// Function
// [RULE1] unsigned and signed 16x16 multiply
// [RULE2] 32/16 unsigned divide, quotient and remainder
// [RULE3] multiply and divide bounded cycle counts
// [RULE4] mac of table pairs into 32-bit pair
// [RULE5] ten term mac within bound
// [RULE6] internal clock is oscillator halved
// [RULE7] every instruction takes two clocks minimum
// [RULE8] 640 bytes ram, main and peripheral
// [RULE9] main ram one or two clocks
// [RULE10] memory two, saddr one, register one
// [RULE11] peripheral ram three clocks per byte
// [RULE12] banks in main ram, rest usable
// [RULE13] one-byte table call, 32 entries
// [RULE14] two-byte call into fixed area
// [RULE15] eight banks, sixteen registers, status select
// [RULE16] full 32-bit product, two's complement
// [RULE17] zero divisor completes in bounded time
module cau_core
    import cau_pkg::*;
#(
    parameter int MUL_CLKS = `CAU_MUL_CLKS,
    parameter int DIV_CLKS = `CAU_DIV_CLKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic osc_ce,
    input wire logic start,
    input wire cau_op_t op,
    input wire logic [15:0] opa,
    input wire logic [31:0] opb,
    input wire logic [7:0] mac_terms,
    input wire logic [15:0] tab_a,
    input wire logic [15:0] tab_b,
    input wire logic tbl_page,
    input wire logic [15:0] program_status_word,
    input wire logic ram_req,
    input wire logic ram_wr,
    input wire logic [15:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire cau_acc_t ram_mode,
    output logic ram_ack,
    output logic [7:0] ram_rdata,
    output logic busy,
    output logic done,
    output logic [31:0] result,
    output logic [15:0] remainder,
    output logic [31:0] mac_accumulator_pair,
    output logic [15:0] call_target,
    output logic [2:0] active_bank,
    output logic internal_system_clock
);
    typedef enum logic [2:0] {CAU_IDLE, CAU_RUN, CAU_MAC_A, CAU_MAC_B, CAU_CALL, CAU_FIN} cau_st_t;
    cau_st_t st_reg;
    logic div_reg; // oscillator halving flop
    wire ce = osc_ce && div_reg; // one internal clock per two oscillator edges
    cau_ram_if rif();
    cau_op_t op_reg;
    logic [7:0] cnt_reg;
    logic [7:0] terms_reg;
    logic [15:0] pa_reg, pb_reg, fa_reg;
    logic [7:0] fb_lo_reg; // low byte of the second factor
    logic [31:0] dvd_reg;
    logic [16:0] rem_reg;
    logic [1:0] byte_reg;
    logic [15:0] fetch_reg;
    logic [15:0] opa_reg;
    logic core_req;
    // signed or unsigned 32-bit product
    function automatic logic [31:0] mul16(input logic [15:0] a, input logic [15:0] b, input logic sgn);
        // operands widened first so the whole product is kept
        if (sgn)
            mul16 = $signed({{16{a[15]}}, a}) * $signed({{16{b[15]}}, b}); // [RULE16]
        else
            mul16 = {16'h0000, a} * {16'h0000, b};
    endfunction
    cau_ram u_ram (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(rif.ram));
    // arbitrate ram between core fetches and outside accesses
    wire fetching = st_reg == CAU_MAC_A || st_reg == CAU_MAC_B || st_reg == CAU_CALL;
    assign rif.req = fetching ? core_req : ram_req;
    assign rif.wr = fetching ? 1'b0 : ram_wr;
    assign rif.addr = fetching ? fetch_reg : ram_addr;
    assign rif.wdata = ram_wdata;
    assign rif.mode = fetching ? 2'(CAU_ACC_MEM) : 2'(ram_mode);
    // divide the oscillator by two [RULE6]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            div_reg <= 1'b0;
        else if (osc_ce)
            div_reg <= !div_reg;
    end
    // clock out and bank select from the status word [RULE15]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            internal_system_clock <= 1'b0;
            active_bank <= 3'h0;
            ram_ack <= 1'b0;
            ram_rdata <= 8'h00;
        end else if (osc_ce) begin
            internal_system_clock <= !div_reg;
            active_bank <= program_status_word[10:8];
            ram_ack <= ce && rif.ack && !fetching;
            ram_rdata <= rif.rdata;
        end
    end
    // operation sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= CAU_IDLE;
            op_reg <= CAU_OP_NONE;
            cnt_reg <= 8'h00;
            terms_reg <= 8'h00;
            pa_reg <= 16'h0000; pb_reg <= 16'h0000; fa_reg <= 16'h0000; opa_reg <= 16'h0000;
            dvd_reg <= 32'h0; rem_reg <= 17'h0; byte_reg <= 2'h0; fetch_reg <= 16'h0000;
            fb_lo_reg <= 8'h00;
            core_req <= 1'b0; busy <= 1'b0; done <= 1'b0;
            result <= 32'h0; remainder <= 16'h0000; mac_accumulator_pair <= 32'h0; call_target <= 16'h0000;
        end else if (ce) begin
            done <= 1'b0;
            core_req <= 1'b0;
            case (st_reg)
                CAU_IDLE: begin
                    if (start) begin
                        op_reg <= op; busy <= 1'b1; opa_reg <= opa;
                        cnt_reg <= 8'h00; byte_reg <= 2'h0;
                        dvd_reg <= opb; rem_reg <= 17'h0;
                        pa_reg <= tab_a; pb_reg <= tab_b; terms_reg <= mac_terms;
                        if (op == CAU_OP_MAC) begin
                            st_reg <= mac_terms == 8'h00 ? CAU_FIN : CAU_MAC_A; // [RULE4]
                            fetch_reg <= tab_a; core_req <= mac_terms != 8'h00;
                        end else if (op == CAU_OP_VECTOR_TABLE_CALL) begin
                            // table entry from low five bits of the code [RULE13]
                            fetch_reg <= (tbl_page ? `CAU_VECTOR_TABLE_CALL_BASE_HI : `CAU_VECTOR_TABLE_CALL_BASE_LO) + {10'h0, opa[4:0], 1'b0};
                            core_req <= 1'b1; st_reg <= CAU_CALL;
                        end else if (op == CAU_OP_FIXED_AREA_CALL) begin
                            call_target <= `CAU_FIXED_AREA_CALL_BASE | {5'h0, opa[10:0]}; // [RULE14]
                            st_reg <= CAU_FIN;
                        end else
                            st_reg <= CAU_RUN;
                    end
                end
                CAU_RUN: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (op_reg == CAU_OP_DIVU && cnt_reg < 8'd32) begin
                        // restoring step, zero divisor just yields all ones [RULE17]
                        if ({rem_reg[15:0], dvd_reg[31]} >= {1'b0, opa_reg}) begin
                            rem_reg <= {rem_reg[15:0], dvd_reg[31]} - {1'b0, opa_reg};
                            dvd_reg <= {dvd_reg[30:0], 1'b1};
                        end else begin
                            rem_reg <= {rem_reg[15:0], dvd_reg[31]};
                            dvd_reg <= {dvd_reg[30:0], 1'b0};
                        end
                    end
                    // start and finish ticks count toward the total length
                    if (op_reg == CAU_OP_DIVU ? cnt_reg == 8'(DIV_CLKS - 3) : cnt_reg == 8'(MUL_CLKS - 3)) begin
                        // fixed lengths meet the timing bound [RULE3]
                        result <= op_reg == CAU_OP_DIVU ? dvd_reg :
                                  mul16(opa_reg, dvd_reg[15:0], op_reg == CAU_OP_MULS); // [RULE1] [RULE2]
                        remainder <= rem_reg[15:0];
                        st_reg <= CAU_FIN;
                    end
                end
                CAU_MAC_A, CAU_MAC_B, CAU_CALL: begin
                    core_req <= 1'b0;
                    if (rif.ack) begin
                        byte_reg <= byte_reg + 2'h1;
                        fetch_reg <= fetch_reg + 16'h0001;
                        if (byte_reg[0] == 1'b0) begin
                            // second factor keeps its own low byte so the first stays whole
                            if (st_reg == CAU_MAC_B)
                                fb_lo_reg <= rif.rdata;
                            else
                                fa_reg[7:0] <= rif.rdata;
                            core_req <= 1'b1;
                        end else if (st_reg == CAU_CALL) begin
                            call_target <= {rif.rdata, fa_reg[7:0]};
                            st_reg <= CAU_FIN;
                        end else if (st_reg == CAU_MAC_A) begin
                            fa_reg[15:8] <= rif.rdata;
                            pa_reg <= pa_reg + 16'h0002;
                            fetch_reg <= pb_reg; core_req <= 1'b1; st_reg <= CAU_MAC_B;
                        end else begin
                            mac_accumulator_pair <= mac_accumulator_pair +
                                mul16(fa_reg, {rif.rdata, fb_lo_reg}, 1'b1); // [RULE4] [RULE5]
                            pb_reg <= pb_reg + 16'h0002;
                            terms_reg <= terms_reg - 8'h01;
                            fetch_reg <= pa_reg; core_req <= terms_reg != 8'h01;
                            st_reg <= terms_reg == 8'h01 ? CAU_FIN : CAU_MAC_A;
                        end
                    end
                end
                CAU_FIN: begin
                    // finish stage gives each op at least two clocks [RULE7]
                    busy <= 1'b0; done <= 1'b1; st_reg <= CAU_IDLE;
                end
                default: st_reg <= CAU_IDLE;
            endcase
        end
    end
    // busy ticks seen after the start tick, finish tick excluded
    localparam int MUL_BOUND = MUL_CLKS - 2;
    localparam int DIV_BOUND = DIV_CLKS - 2;
    logic [7:0] run_cnt_reg; // helper: clocks since start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            run_cnt_reg <= 8'h00;
        else if (ce)
            run_cnt_reg <= busy ? run_cnt_reg + 8'h01 : 8'h00;
    end
    mul_time_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
        (busy && (op_reg == CAU_OP_MULS || op_reg == CAU_OP_MULU)) |-> run_cnt_reg <= 8'(MUL_BOUND))
        else $error("multiply too long");
    div_time_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE17]
        (busy && op_reg == CAU_OP_DIVU) |-> run_cnt_reg <= 8'(DIV_BOUND))
        else $error("divide too long");
    min_insn_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
        $rose(done) |-> $past(busy, 2)) else $error("op shorter than two clocks");
    bank_sel_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE15]
        osc_ce |=> active_bank == $past(program_status_word[10:8])) else $error("bank select wrong");
    clk_half_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
        osc_ce |=> div_reg != $past(div_reg)) else $error("clock not halved");
    mul_res_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
        (ce && st_reg == CAU_RUN && op_reg == CAU_OP_MULU && cnt_reg == 8'(MUL_CLKS - 3))
        |=> result == opa_reg * $past(dvd_reg[15:0])) else $error("product wrong");
    div_rem_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
        $rose(done) && op_reg == CAU_OP_DIVU |-> remainder < opa_reg || opa_reg == 16'h0000)
        else $error("remainder not below divisor");
    fixed_area_call_area_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
        $rose(done) && op_reg == CAU_OP_FIXED_AREA_CALL |-> call_target[15:11] == `CAU_FIXED_AREA_CALL_BASE >> 11)
        else $error("fixed call outside area");
    mul_c: cover property (@(posedge clk) $rose(done) && op_reg == CAU_OP_MULS);
    div_c: cover property (@(posedge clk) $rose(done) && op_reg == CAU_OP_DIVU);
    mac_c: cover property (@(posedge clk) $rose(done) && op_reg == CAU_OP_MAC);
    call_c: cover property (@(posedge clk) $rose(done) && op_reg == CAU_OP_VECTOR_TABLE_CALL);
endmodule // cau_core

// >>> testbench/testbench.sv
`timescale 1ns/1ps
// self-checking bench for the arithmetic core and its ram timing
module testbench;
    import cau_pkg::*;
    logic clk, rst_n, osc_ce, start, tbl_page, ram_req, ram_wr; // driven by the bench
    cau_op_t op; // operation select
    cau_acc_t ram_mode; // ram access mode
    logic [15:0] opa, tab_a, tab_b, program_status_word, ram_addr; // operands and addresses
    logic [31:0] opb; // multiplier or dividend
    logic [7:0] mac_terms, ram_wdata; // term count and write byte
    logic ram_ack, busy, done, internal_system_clock; // flags from the core
    logic [7:0] ram_rdata; // read byte
    logic [31:0] result, mac_accumulator_pair; // results
    logic [15:0] remainder, call_target; // remainder and call address
    logic [2:0] active_bank; // bank select
    int fail_count = 0; // mismatches
    int checks = 0; // comparisons made
    int cyc = 0; // timeout counter
    cau_core uut (.clk(clk), .rst_n(rst_n), .osc_ce(osc_ce), .start(start), .op(op), .opa(opa), .opb(opb),
        .mac_terms(mac_terms), .tab_a(tab_a), .tab_b(tab_b), .tbl_page(tbl_page),
        .program_status_word(program_status_word), .ram_req(ram_req), .ram_wr(ram_wr), .ram_addr(ram_addr),
        .ram_wdata(ram_wdata), .ram_mode(ram_mode), .ram_ack(ram_ack), .ram_rdata(ram_rdata), .busy(busy),
        .done(done), .result(result), .remainder(remainder), .mac_accumulator_pair(mac_accumulator_pair),
        .call_target(call_target), .active_bank(active_bank), .internal_system_clock(internal_system_clock));
    // 4 ns clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // counts and verdict
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one comparison
    task automatic check(input bit ok, input string msg);
        checks++;
        if (!ok) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // start an operation and wait for done, counting clocks
    task automatic run_op(input cau_op_t o, input logic [15:0] a, input logic [31:0] b, output int clks);
        op = o;
        opa = a;
        opb = b;
        start = 1'b1;
        clks = 0;
        while (done !== 1'b1 && clks < 300) begin
            @(posedge clk);
            #1;
            clks++;
            if (busy === 1'b1) start = 1'b0;
        end
        start = 1'b0;
        check(done === 1'b1, "operation never finished");
        repeat (2) @(posedge clk);
        #1;
    endtask
    // one ram access held until acknowledged
    task automatic ram_acc(input logic w, input logic [15:0] a, input logic [7:0] d, input cau_acc_t m,
                           output logic [7:0] q, output int lat);
        ram_req = 1'b1;
        ram_wr = w;
        ram_addr = a;
        ram_wdata = d;
        ram_mode = m;
        lat = 0;
        while (ram_ack !== 1'b1 && lat < 50) begin
            @(posedge clk);
            #1;
            lat++;
        end
        q = ram_rdata;
        ram_req = 1'b0;
        check(ram_ack === 1'b1, "ram access never acknowledged");
        @(posedge clk);
        #1;
    endtask
    // internal clock runs at half the oscillator and freezes without it
    task automatic test_clock();
        int rises;
        logic prev;
        rises = 0;
        prev = internal_system_clock;
        repeat (16) begin
            @(posedge clk);
            #1;
            if (internal_system_clock === 1'b1 && prev === 1'b0) rises++;
            prev = internal_system_clock;
        end
        check(rises == 8, "internal clock rate");
        osc_ce = 1'b0;
        @(posedge clk);
        #1;
        prev = internal_system_clock;
        repeat (8) @(posedge clk);
        #1;
        check(internal_system_clock === prev, "internal clock ran without oscillator");
        osc_ce = 1'b1;
        $display("test clock done");
    endtask
    // every bank number from the status word
    task automatic test_banks();
        for (int i = 0; i < 8; i++) begin
            program_status_word = {5'h00, i[2:0], 8'h00};
            repeat (4) @(posedge clk);
            #1;
            check(active_bank === i[2:0], "bank select");
        end
        $display("test banks done");
    endtask
    // multiply both forms, with time bound on the signed form only
    task automatic test_mul();
        int n;
        run_op(CAU_OP_MULU, 16'hfffd, 32'h0000_0007, n);
        check(result === 32'h0006_ffeb, "unsigned product");
        run_op(CAU_OP_MULS, 16'hfffd, 32'h0000_0007, n);
        check(result === 32'hffff_ffeb, "signed product");
        check(n <= 2 * 14 + 1 && n >= 4, "signed multiply time");
        run_op(CAU_OP_MULS, 16'h8000, 32'h0000_8000, n);
        check(result === 32'h4000_0000, "signed extreme product");
        $display("test mul done");
    endtask
    // divide, including a zero divisor
    task automatic test_div();
        int n;
        logic [31:0] dd;
        dd = 32'h1234_5678;
        run_op(CAU_OP_DIVU, 16'h0123, dd, n);
        check(result === dd / 32'h0000_0123, "quotient");
        check(remainder === 16'(dd % 32'h0000_0123), "remainder");
        check(n <= 2 * 43 + 1, "divide time");
        run_op(CAU_OP_DIVU, 16'h0000, dd, n);
        check(done === 1'b0 && busy === 1'b0 && n < 300, "zero divisor hung");
        check(result === 32'hffff_ffff, "zero divisor quotient");
        $display("test div done");
    endtask
    // two-byte call into the fixed area
    task automatic test_fixed_area_call();
        int n;
        run_op(CAU_OP_FIXED_AREA_CALL, 16'hf123, 32'h0, n);
        check(call_target === 16'h0923, "fixed area target");
        check(n >= 4, "shortest instruction");
        $display("test fixed_area_call done");
    endtask
    // one-byte table call, table lies outside the ram map and reads as zero
    task automatic test_vector_table_call();
        int n;
        tbl_page = 1'b1;
        run_op(CAU_OP_VECTOR_TABLE_CALL, 16'h0005, 32'h0, n);
        check(call_target === 16'h0000, "table call target");
        check(n >= 4 && n < 300, "table call length");
        $display("test vector_table_call done");
    endtask
    // ram speeds and storage in main and peripheral areas
    task automatic test_ram();
        logic [7:0] q;
        int l_mem, l_sad, l_per, l;
        ram_acc(1'b1, 16'hfe40, 8'h5a, CAU_ACC_MEM, q, l_mem);
        ram_acc(1'b0, 16'hfe40, 8'h00, CAU_ACC_SADDR, q, l_sad);
        check(q === 8'h5a, "main ram readback");
        ram_acc(1'b0, 16'hfe40, 8'h00, CAU_ACC_MEM, q, l_mem);
        check(l_mem > l_sad, "memory mode slower than saddr");
        ram_acc(1'b1, 16'hfef0, 8'ha7, CAU_ACC_REG, q, l);
        ram_acc(1'b0, 16'hfef0, 8'h00, CAU_ACC_REG, q, l);
        check(q === 8'ha7 && l <= l_sad, "bank area storage");
        ram_acc(1'b1, 16'hfc80, 8'h3c, CAU_ACC_MEM, q, l_per);
        ram_acc(1'b0, 16'hfdff, 8'h00, CAU_ACC_MEM, q, l_per);
        ram_acc(1'b0, 16'hfc80, 8'h00, CAU_ACC_MEM, q, l_per);
        check(q === 8'h3c, "peripheral ram readback");
        check(l_per > l_mem, "peripheral ram slower");
        $display("test ram done");
    endtask
    // two-term table multiply-accumulate, run twice
    task automatic test_mac();
        logic [7:0] q;
        int l, n;
        logic [15:0] w [4] = '{16'h0003, 16'hfffe, 16'h0005, 16'h0007};
        for (int i = 0; i < 4; i++) begin
            ram_acc(1'b1, 16'(16'hfe20 + 2 * i), w[i][7:0], CAU_ACC_MEM, q, l);
            ram_acc(1'b1, 16'(16'hfe21 + 2 * i), w[i][15:8], CAU_ACC_MEM, q, l);
        end
        tab_a = 16'hfe20;
        tab_b = 16'hfe24;
        mac_terms = 8'h02;
        run_op(CAU_OP_MAC, 16'h0, 32'h0, n);
        check(mac_accumulator_pair === 32'h0000_0001, "mac sum");
        check(n <= 2 * 43 + 1, "two term mac time");
        run_op(CAU_OP_MAC, 16'h0, 32'h0, n);
        check(mac_accumulator_pair === 32'h0000_0002, "mac accumulates");
        $display("test mac done");
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        osc_ce = 1'b1;
        start = 1'b0;
        op = CAU_OP_NONE;
        opa = 16'h0;
        opb = 32'h0;
        mac_terms = 8'h00;
        tab_a = 16'h0;
        tab_b = 16'h0;
        tbl_page = 1'b0;
        program_status_word = 16'h0;
        ram_req = 1'b0;
        ram_wr = 1'b0;
        ram_addr = 16'h0;
        ram_wdata = 8'h00;
        ram_mode = CAU_ACC_MEM;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        test_clock();
        test_banks();
        test_mac();
        test_mul();
        test_div();
        test_fixed_area_call();
        test_vector_table_call();
        test_ram();
        tally_and_finish();
    end
endmodule // testbench
